// ---- logic/ddp_top.sv ----
// ddp_top: serial control/status port, supply, short, thermal and inhibit protection
// assumes every input except MCLK/RST comes from outside the clock domain
`timescale 1ns/1ps

module ddp_top
  import ddp_pkg::*;
#(
  parameter int SC_LONG_CYC  = SC_LONG_US * CLK_MHZ,   // short delay, long setting
  parameter int SC_SHORT_CYC = SC_SHORT_US * CLK_MHZ,  // short delay, short setting
  parameter int OV_LONG_CYC  = OV_LONG_US * CLK_MHZ,   // overvoltage delay, long
  parameter int OV_SHORT_CYC = OV_SHORT_US * CLK_MHZ,  // overvoltage delay, short
  parameter int UV_CYC       = UV_US * CLK_MHZ         // undervoltage delay
)
(
  input  wire logic               MCLK,         // system clock, 200 MHz
  input  wire logic               RST,          // async reset, active high
  input  wire logic               CS_N,         // chip select, low = selected
  input  wire logic               SCK,          // serial clock from controller
  input  wire logic               SERIAL_IN,    // serial data in, LSB first
  input  wire logic               INHIBIT_N,    // inhibit pin, low = standby
  input  wire logic               PW_SET,       // prewarning set comparator
  input  wire logic               PW_RESET,     // prewarning reset comparator (cooled)
  input  wire logic               TEMP_SHUT,    // thermal shutdown comparator
  input  wire logic               TEMP_SW_ON,   // switch-on comparator (cooled)
  input  wire logic               SUPPLY_OV,    // supply overvoltage comparator
  input  wire logic               SUPPLY_UV,    // supply undervoltage comparator
  input  wire logic [NUM_DRV-1:0] OPEN_LOAD,    // open-load comparators per driver
  input  wire logic [NUM_DRV-1:0] CUR_LIMIT,    // current limit active per driver
  output logic                    SERIAL_OUT,   // serial data out
  output logic                    SERIAL_OE,    // serial out enable, high = driving
  output logic [NUM_DRV-1:0]      DRV_EN,       // driver enables
  output logic [NUM_DRV-1:0]      TEST_CUR_EN   // open-load test current enables
);

  // parameter sanity
  if (SC_LONG_CYC < 2 || SC_SHORT_CYC < 2 || OV_LONG_CYC < 2 || OV_SHORT_CYC < 2
      || UV_CYC < 2)
  begin : g_bad_param
    $error("ddp_top: delay counts must be at least 2 cycles");
  end

  // three-flop synchroniser with agreement filter
  logic [NUM_PIN-1:0] raw_w;
  logic [NUM_PIN-1:0] s1_q;
  logic [NUM_PIN-1:0] s2_q;
  logic [NUM_PIN-1:0] s3_q;
  logic [NUM_PIN-1:0] flt_q;
  logic [NUM_PIN-1:0] flt_d;

  assign raw_w = {CUR_LIMIT, OPEN_LOAD, SUPPLY_UV, SUPPLY_OV, TEMP_SW_ON, TEMP_SHUT,
                  PW_RESET, PW_SET, INHIBIT_N, SERIAL_IN, SCK, CS_N};
  assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q)) | (~(s2_q ^ s3_q) & s3_q);

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      s1_q  <= PIN_RESET;
      s2_q  <= PIN_RESET;
      s3_q  <= PIN_RESET;
      flt_q <= PIN_RESET;
    end
    else
    begin
      s1_q  <= raw_w;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  // named filtered levels
  logic               cs_n;
  logic               sck;
  logic               sdi;
  logic               stby_pin_n;
  logic               pw_set;
  logic               pw_rst;
  logic               t_shut;
  logic               t_on;
  logic               sup_ov;
  logic               sup_uv;
  logic [NUM_DRV-1:0] ol_w;
  logic [NUM_DRV-1:0] cl_w;

  assign cs_n   = flt_q[PIN_CS];
  assign sck    = flt_q[PIN_SCK];
  assign sdi    = flt_q[PIN_SDI];
  assign stby_pin_n = flt_q[PIN_STBY];
  assign pw_set = flt_q[PIN_PWS];
  assign pw_rst = flt_q[PIN_PWR];
  assign t_shut = flt_q[PIN_TSD];
  assign t_on   = flt_q[PIN_TON];
  assign sup_ov = flt_q[PIN_OV];
  assign sup_uv = flt_q[PIN_UV];
  assign ol_w   = flt_q[PIN_OL +: NUM_DRV];
  assign cl_w   = flt_q[PIN_CL +: NUM_DRV];

  // edge detection on chip select and serial clock
  logic cs_prev_q;
  logic sck_prev_q;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  assign cs_fall  = cs_prev_q & ~cs_n;
  assign cs_rise  = ~cs_prev_q & cs_n;
  assign sck_rise = ~sck_prev_q & sck & ~cs_n;
  assign sck_fall = sck_prev_q & ~sck & ~cs_n;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      cs_prev_q  <= cs_n;
      sck_prev_q <= sck;
    end
  end

  // protection state
  ddp_ctrl_s          ctrl_q;
  logic               clr_q;        // one-cycle fault clear pulse
  logic               pwarn_q;      // prewarning flag
  logic               therm_q;      // thermal shutdown latch
  logic               sfail_q;      // supply fail flag
  logic               sup_off_q;    // drivers held off by supply
  logic               sflt_q;       // short flag
  logic [NUM_DRV-1:0] sc_off_q;     // drivers cut by shorts
  logic [NUM_DRV-1:0] sc_trip;
  logic [NUM_DRV-1:0] lim_v;
  logic               standby;
  logic [NUM_DRV-1:0] drv_en_d;
  logic [NUM_DRV-1:0] test_cur_d;
  logic               ol_test;

  assign standby  = ~ctrl_q.run_en | ~stby_pin_n;
  assign drv_en_d = ctrl_q.drv_on & ~sc_off_q
                    & {NUM_DRV{~(sup_off_q | therm_q | standby)}};
  assign ol_test    = ~ctrl_q.open_load_test_en_n;
  assign test_cur_d = {NUM_DRV{ol_test}} & ~ctrl_q.drv_on;
  assign lim_v      = cl_w & DRV_EN;

  // status word assembly
  ddp_stat_s          stat_n;
  logic [15:0]        status_w;
  logic [NUM_DRV-1:0] drv_stat;

  assign drv_stat = (ol_test ? ~ctrl_q.drv_on & ol_w : '0)
                    | (~(ol_test ? ~ctrl_q.drv_on : '0) & DRV_EN);
  assign stat_n.temp_prewarn_flag  = pwarn_q | therm_q;
  assign stat_n.drv_status         = drv_stat;
  assign stat_n.short_fault_flag   = sflt_q;
  assign stat_n.standby_indication = standby;
  assign stat_n.supply_fail_flag   = sfail_q;
  assign status_w = therm_q ? '1 : stat_n;

  // serial shift registers
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [4:0]  cnt_q;
  logic        commit;

  assign commit = cs_rise & (cnt_q >= 5'(WORD_BITS));

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      tx_q       <= '0;
      rx_q       <= '0;
      cnt_q      <= '0;
      SERIAL_OUT <= 1'b0;
      SERIAL_OE  <= 1'b0;
    end
    else
    begin
      SERIAL_OE <= ~cs_n;
      if (cs_fall)
      begin
        tx_q       <= status_w;
        SERIAL_OUT <= status_w[0];
        cnt_q      <= '0;
      end
      else if (sck_rise)
      begin
        tx_q       <= {1'b0, tx_q[15:1]};
        SERIAL_OUT <= tx_q[1];
      end
      if (sck_fall)
      begin
        rx_q <= {sdi, rx_q[15:1]};
        if (cnt_q < 5'(WORD_BITS))
          cnt_q <= cnt_q + 5'h1;
      end
    end
  end

  // control register, applied only on a full word
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q <= CTRL_RESET;
      clr_q  <= 1'b0;
    end
    else
    begin
      if (commit)
        ctrl_q <= rx_q;
      clr_q <= commit & rx_q[CTL_CLR_BIT];
    end
  end

  // thermal flags
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pwarn_q <= 1'b0;
      therm_q <= 1'b0;
    end
    else
    begin
      pwarn_q <= pw_set | (pwarn_q & ~pw_rst);
      therm_q <= t_shut | (therm_q & ~(clr_q & t_on));
    end
  end

  // supply fail timer
  logic [31:0] sup_cnt_q;
  logic [31:0] sup_dly;
  logic        sup_bad;
  logic        sup_trip;

  assign sup_bad  = sup_ov | sup_uv;
  assign sup_dly  = sup_ov ? (ctrl_q.shutdown_delay_sel ? 32'(OV_LONG_CYC)
                                                         : 32'(OV_SHORT_CYC))
                           : 32'(UV_CYC);
  assign sup_trip = sup_bad & (sup_cnt_q >= sup_dly - 32'h1);

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sup_cnt_q <= '0;
      sup_off_q <= 1'b0;
      sfail_q   <= 1'b0;
    end
    else
    begin
      sup_cnt_q <= (sup_bad & ~sup_trip) ? sup_cnt_q + 32'h1 : '0;
      sup_off_q <= sup_bad & (sup_trip | sup_off_q);
      sfail_q   <= sup_trip | (sfail_q & ~clr_q);
    end
  end

  // per-driver short timers
  logic [31:0] sc_dly;

  assign sc_dly = ctrl_q.shutdown_delay_sel ? 32'(SC_LONG_CYC)
                                            : 32'(SC_SHORT_CYC);

  for (genvar i = 0; i < NUM_DRV; i++)
  begin : g_short
    logic [31:0] cnt_q;

    assign sc_trip[i] = lim_v[i] & (pwarn_q
                        | (cnt_q >= sc_dly - 32'h1));

    always_ff @(posedge MCLK or posedge RST)
    begin
      if (RST)
      begin
        cnt_q       <= '0;
        sc_off_q[i] <= 1'b0;
      end
      else
      begin
        cnt_q       <= (lim_v[i] & ~sc_trip[i]) ? cnt_q + 32'h1 : '0;
        sc_off_q[i] <= sc_trip[i] | (sc_off_q[i] & ~clr_q);
      end
    end
  end

  // short flag and output registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sflt_q      <= 1'b0;
      DRV_EN      <= '0;
      TEST_CUR_EN <= '0;
    end
    else
    begin
      sflt_q      <= (|sc_trip) | (sflt_q & ~clr_q);
      DRV_EN      <= drv_en_d;
      TEST_CUR_EN <= test_cur_d;
    end
  end

  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_out_tristate: assert property (cs_n |=> !SERIAL_OE)
    else $error("serial out driven while deselected");
  a_prewarn_first: assert property (cs_fall |=> SERIAL_OUT == $past(status_w[0]))
    else $error("prewarning not on serial out at select fall");
  a_abort_keep: assert property (cs_rise && cnt_q < 5'(WORD_BITS)
                                 |=> ctrl_q == $past(ctrl_q) && !clr_q)
    else $error("short frame changed control");
  a_word_commit: assert property (commit |=> ctrl_q == $past(rx_q))
    else $error("full word not applied");
  a_therm_cut: assert property (therm_q && !(clr_q && t_on) |=> DRV_EN == '0
                                ##1 DRV_EN == '0)
    else $error("driver on during thermal shutdown");
  a_sfail_hold: assert property (sfail_q && !clr_q |=> sfail_q)
    else $error("supply fail flag dropped without clear");
  a_sup_return: assert property (sup_off_q && !sup_bad |=> !sup_off_q)
    else $error("drivers not re-enabled after supply return");
  a_prewarn_short: assert property (pwarn_q && (|lim_v) |=> sflt_q
                                    ##1 (DRV_EN & $past(lim_v, 2)) == '0)
    else $error("short under prewarning not cut at once");
  a_clear_short: assert property (clr_q && !(|sc_trip) |=> !sflt_q && sc_off_q == '0)
    else $error("clear did not reset short state");
  a_standby_off: assert property (standby |=> DRV_EN == '0)
    else $error("driver on in standby");
  a_test_current: assert property (ol_test |=> TEST_CUR_EN == ~$past(ctrl_q.drv_on))
    else $error("test currents wrong");

  c_full_word: cover property (commit && rx_q[CTL_CLR_BIT]);
  c_abort: cover property (cs_rise && cnt_q == 5'h0);
  c_short_trip: cover property (|sc_trip);
  c_supply_trip: cover property (sup_trip);

endmodule : ddp_top

// ---- logic/ddp_pkg.sv ----
// ddp_pkg: shared constants and types of the driver diagnostic/protection block
// assumes a 200 MHz system clock; all timer figures are scaled from it
package ddp_pkg;

  // clock rate, driver count and word length
  localparam int CLK_MHZ    = 200;
  localparam int NUM_DRV    = 12;
  localparam int WORD_BITS  = 16;

  // protection delays in microseconds, as printed
  localparam int SC_LONG_US   = 100000;  // short delay, select high
  localparam int SC_SHORT_US  = 12500;   // short delay, select low
  localparam int OV_LONG_US   = 15000;   // overvoltage delay, select high
  localparam int OV_SHORT_US  = 3500;    // overvoltage delay, select low
  localparam int UV_US        = 1000;    // undervoltage delay, chosen value

  // control word bit positions
  localparam int CTL_CLR_BIT  = 0;
  localparam int CTL_DRV_LSB  = 1;

  // control word reset: run, long delays, open-load test off
  localparam logic [15:0] CTRL_RESET = 16'he000;

  // index of each outside-domain input in the synchroniser vector
  localparam int PIN_CS   = 0;
  localparam int PIN_SCK  = 1;
  localparam int PIN_SDI  = 2;
  localparam int PIN_STBY = 3;
  localparam int PIN_PWS  = 4;
  localparam int PIN_PWR  = 5;
  localparam int PIN_TSD  = 6;
  localparam int PIN_TON  = 7;
  localparam int PIN_OV   = 8;
  localparam int PIN_UV   = 9;
  localparam int PIN_OL   = 10;
  localparam int PIN_CL   = PIN_OL + NUM_DRV;
  localparam int NUM_PIN  = PIN_CL + NUM_DRV;

  // idle level of each input: chip select and inhibit pin high
  localparam logic [NUM_PIN-1:0] PIN_RESET = 34'h0_0000_0009;

  // control word as received, LSB first
  typedef struct packed {
    logic                run_en;               // 1 = normal, 0 = software standby
    logic                shutdown_delay_sel;   // 1 = long delays
    logic                open_load_test_en_n;  // 0 = open-load test on
    logic [NUM_DRV-1:0]  drv_on;               // lsd1, hsd1, lsd2 ... hsd6
    logic                fault_clear_cmd;      // 1 = clear latched faults
  } ddp_ctrl_s;

  // status word shifted out, LSB first
  typedef struct packed {
    logic                supply_fail_flag;
    logic                standby_indication;
    logic                short_fault_flag;
    logic [NUM_DRV-1:0]  drv_status;
    logic                temp_prewarn_flag;
  } ddp_stat_s;

endpackage : ddp_pkg

// ---- bench/ddp_mcu.sv ----
// ddp_mcu: behavioural controller that frames serial transfers to the protection block
// assumes it shares the system clock and moves its pins just after rising edges
`timescale 1ns/1ps

module ddp_mcu
  import ddp_pkg::*;
(
  input  wire logic clk,     // pacing clock
  output logic      cs_n,    // chip select, low = selected
  output logic      sck,     // serial clock, 160 ns period
  output logic      sdo,     // data towards the device
  input  wire logic sdi,     // data from the device
  input  wire logic sdi_oe   // device output enable
);
  // a released output reads as floating, never as a stale level
  wire logic sdi_w = sdi_oe ? sdi : 1'bz;

  // idle levels: select pulled up, clock and data pulled down
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdo  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // one frame of nb bits lsb first; fewer than sixteen leaves it incomplete
  task automatic xfer(input logic [WORD_BITS-1:0] c, input int nb,
                      output logic [WORD_BITS-1:0] s);
    s = '0;
    cs_n <= 1'b0;
    wt(16);
    s[0] = sdi_w;
    for (int i = 0; i < nb; i++)
    begin
      sck <= 1'b1;
      sdo <= c[i];
      wt(16);
      sck <= 1'b0;
      wt(16);
      if (i < WORD_BITS - 1)
        s[i+1] = sdi_w;
    end
    cs_n <= 1'b1;
    sdo  <= 1'b0;
    wt(16);
  endtask : xfer

endmodule : ddp_mcu

// ---- bench/ddp_top_tb.sv ----
// ddp_top_tb: self-checking bench for the protection block with a serial controller model
// assumes small delay parameters so every protection timer trips within a few cycles
`timescale 1ns/1ps

module ddp_top_tb
  import ddp_pkg::*;
;
  localparam int SCS = 10, SCL = 20, OVS = 8, OVL = 16, UVC = 12;
  logic               mclk, rst, stby_n, pw_set, pw_rst, t_shut, t_on, s_ov, s_uv;
  logic [NUM_DRV-1:0] ol, cl, d;
  wire logic [NUM_DRV-1:0] drv_en, tc_en;
  wire logic          cs_n, sck, sdi, so, so_oe;
  int                 error_cnt, cmp_count, k;
  logic [15:0]        s;
  ddp_ctrl_s          cur;

  ddp_top #(.SC_LONG_CYC(SCL), .SC_SHORT_CYC(SCS), .OV_LONG_CYC(OVL), .OV_SHORT_CYC(OVS),
            .UV_CYC(UVC)) i_dut (
    .MCLK(mclk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SERIAL_IN(sdi), .INHIBIT_N(stby_n),
    .PW_SET(pw_set), .PW_RESET(pw_rst), .TEMP_SHUT(t_shut), .TEMP_SW_ON(t_on),
    .SUPPLY_OV(s_ov), .SUPPLY_UV(s_uv), .OPEN_LOAD(ol), .CUR_LIMIT(cl), .SERIAL_OUT(so),
    .SERIAL_OE(so_oe), .DRV_EN(drv_en), .TEST_CUR_EN(tc_en));

  ddp_mcu i_mcu (.clk(mclk), .cs_n(cs_n), .sck(sck), .sdo(sdi), .sdi(so), .sdi_oe(so_oe));

  // 200 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic de(input logic [NUM_DRV-1:0] e);
    chk("drv_en", 16'(e), 16'(drv_en));
  endtask : de

  function automatic ddp_ctrl_s mk(logic [11:0] dv, logic sel, logic olt_n, logic run, logic clr);
    return '{run, sel, olt_n, dv, clr};
  endfunction : mk

  // expected status; hi holds supply fail, standby, short, prewarn
  function automatic logic [15:0] est(logic [11:0] dv, logic [3:0] hi);
    return ddp_stat_s'{hi[3], hi[2], hi[1], dv, hi[0]};
  endfunction : est

  // full write frame; the clear bit is not repeated afterwards
  task automatic wr(input ddp_ctrl_s c);
    i_mcu.xfer(c, 16, s);
    cur = c;
    cur.fault_clear_cmd = 1'b0;
    wt(24);
  endtask : wr

  task automatic rd();
    i_mcu.xfer(cur, 16, s);
    wt(24);
  endtask : rd

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // watchdog against a hung handshake
  initial
  begin
    wt(90000);
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    stby_n = 1'b1;
    pw_set = 1'b0;
    pw_rst = 1'b1;
    t_shut = 1'b0;
    t_on = 1'b1;
    s_ov = 1'b0;
    s_uv = 1'b0;
    ol = '0;
    cl = '0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(1));
    wt(6);
    rst <= 1'b0;
    wt(8);
    chk("rst_out", 16'h0, {4'h0, drv_en | tc_en});
    cur = CTRL_RESET;
    // random driver words read back through the status word
    repeat (6)
    begin
      d = 12'($urandom);
      wr(mk(d, 1'($urandom), 1'b1, 1'b1, 1'b0));
      de(d);
      rd();
      chk("stat", est(d, 4'h0), s);
      chk("oe_idle", 16'h0, 16'(so_oe));
    end
    // standby by pin, then by software bit, then resume
    d = 12'($urandom) | 12'h1;
    for (int m = 0; m < 2; m++)
    begin
      stby_n <= 1'(m);
      wr(mk(d, 1'b1, 1'b1, m == 0, 1'b0));
      de(12'h0);
      rd();
      chk("standby", 16'h4000, s & 16'h4000);
    end
    wr(mk(d, 1'b1, 1'b1, 1'b1, 1'b0));
    de(d);
    // open-load test: currents for off drivers, comparator shown for them
    ol <= 12'($urandom);
    wr(mk(d, 1'b1, 1'b0, 1'b1, 1'b0));
    chk("test_cur", {4'h0, ~d}, 16'(tc_en));
    rd();
    chk("ol_stat", est(d | (ol & ~d), 4'h0), s);
    wr(mk(d, 1'b1, 1'b1, 1'b1, 1'b0));
    chk("test_off", 16'h0, 16'(tc_en));
    // prewarning hysteresis read by incomplete frames that must change nothing
    for (int j = 0; j < 3; j++)
    begin
      pw_set <= (j == 0);
      pw_rst <= (j == 2);
      wt(10);
      i_mcu.xfer(mk(12'hfff, 1'b0, 1'b0, 1'b0, 1'b1), j, s);
      chk("prewarn", 16'(j != 2), 16'(s[0]));
      wt(24);
      de(d);
    end
    // short circuit under both delay settings, then cleared
    for (int sel = 0; sel < 2; sel++)
    begin
      k = $urandom_range(NUM_DRV - 1);
      d = 12'($urandom) | (12'h1 << k);
      wr(mk(d, 1'(sel), 1'b1, 1'b1, 1'b0));
      cl <= 12'h1 << k;
      wt(sel ? SCL - 2 : SCS - 2);
      de(d);
      wt(30);
      de(d & ~(12'h1 << k));
      cl <= 12'h0;
      rd();
      chk("short", est(d & ~(12'h1 << k), 4'h2), s);
      wr(mk(d, 1'(sel), 1'b1, 1'b1, 1'b1));
      de(d);
    end
    // prewarning during a limit cuts well before the long delay
    pw_set <= 1'b1;
    pw_rst <= 1'b0;
    wt(10);
    cl <= 12'h1 << k;
    wt(12);
    de(d & ~(12'h1 << k));
    cl <= 12'h0;
    pw_set <= 1'b0;
    pw_rst <= 1'b1;
    wt(10);
    // supply faults: delayed cut, instant return, flag held until cleared
    for (int v = 0; v < 3; v++)
    begin
      wr(mk(d, 1'(v == 2), 1'b1, 1'b1, 1'b1));
      s_ov <= (v != 1);
      s_uv <= (v == 1);
      wt(v == 1 ? UVC - 2 : (v == 2 ? OVL - 2 : OVS - 2));
      de(d);
      wt(30);
      de(12'h0);
      rd();
      chk("sfail", 16'h8000, s & 16'he001);
      s_ov <= 1'b0;
      s_uv <= 1'b0;
      wt(10);
      de(d);
      rd();
      chk("sfail_held", 16'h8000, s & 16'he001);
      wr(mk(d, 1'(v == 2), 1'b1, 1'b1, 1'b1));
      rd();
      chk("sfail_clr", est(d, 4'h0), s);
    end
    // thermal latch released only when cooled and cleared
    t_shut <= 1'b1;
    t_on <= 1'b0;
    wt(10);
    de(12'h0);
    rd();
    chk("thermal", 16'hffff, s);
    t_shut <= 1'b0;
    wt(10);
    wr(mk(d, 1'b0, 1'b1, 1'b1, 1'b1));
    de(12'h0);
    t_on <= 1'b1;
    wt(10);
    wr(mk(d, 1'b0, 1'b1, 1'b1, 1'b1));
    de(d);
    end_of_test();
  end

endmodule : ddp_top_tb
